// [hdl/rcs_pkg.sv]
// Package for the reset-cause and core status block.
// Assumes a single core clock and an APB register slave.
package rcs_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [11:0] OFS_POWER_RESET_CAUSE = 12'h000;
	localparam logic [11:0] OFS_CORE_STATUS       = 12'h004;
	localparam logic [11:0] OFS_CAUSE_CTRL        = 12'h008;
	localparam logic [11:0] OFS_PC_START          = 12'h00c;
	localparam logic [11:0] OFS_WAKE_SOURCE       = 12'h010;

	// ==========================================================
	// Field positions, power control register
	localparam int PCR_PARITY_MIRROR = 7;
	localparam int PCR_PARITY_FAULT  = 2;
	localparam int PCR_POWER_ON      = 1;
	localparam int PCR_BROWNOUT      = 0;

	// Field positions, core status register
	localparam int CST_INDIRECT_BANK = 7;
	localparam int CST_BANK_HI       = 6;
	localparam int CST_BANK_LO       = 5;
	localparam int CST_WDOG_EXPIRY   = 4;
	localparam int CST_SLEEP_ENTERED = 3;
	localparam int CST_ZERO          = 2;
	localparam int CST_NIBBLE_CARRY  = 1;
	localparam int CST_CARRY         = 0;

	// ==========================================================
	// Reset values and vectors
	localparam logic [7:0]  PCR_RESET       = 8'h00;
	localparam logic [7:0]  CST_RESET       = 8'h18;
	localparam logic [12:0] PC_RESET_VECTOR = 13'h0000;
	localparam logic [12:0] PC_INT_VECTOR   = 13'h0004;
	// Wake-up flag bits: interrupt register / peripheral register
	localparam int WAKE_INT_BIT   = 1;
	localparam int WAKE_TIMER_BIT = 0;

	// Reset/initialisation classes
	typedef enum logic [1:0] {
		RCS_CLASS_NONE  = 2'b00,
		RCS_CLASS_POWER = 2'b01,
		RCS_CLASS_WARM  = 2'b11,
		RCS_CLASS_WAKE  = 2'b10
	} rcs_class_e;

	// ALU operation kinds for flag update
	typedef enum logic [2:0] {
		RCS_ALU_NONE  = 3'h0,
		RCS_ALU_ADD   = 3'h1,
		RCS_ALU_SUB   = 3'h2,
		RCS_ALU_LOGIC = 3'h3,
		RCS_ALU_RLF   = 3'h4,
		RCS_ALU_RRF   = 3'h5
	} rcs_alu_e;

	// Reset-source event strobes (one-cycle pulses)
	typedef struct packed {
		logic power_on;
		logic brownout;
		logic parity;
		logic pin_reset_run;
		logic pin_reset_sleep;
		logic wdog_reset;
		logic wdog_wake;
		logic int_wake;
	} rcs_event_s;

	// ALU operand interface
	typedef struct packed {
		rcs_alu_e   op;
		logic [7:0] a;
		logic [7:0] b;
	} rcs_alu_s;

	// Whole state of the block
	typedef struct packed {
		logic [7:0]  pcr;
		logic [7:0]  cst;
		logic [12:0] pc_start;
		logic        pc_load;
		rcs_class_e  rclass;
		logic [1:0]  wake_src;
	} rcs_state_s;

endpackage : rcs_pkg

// [hdl/rcs_core.sv]
// Reset-cause recording and core status register block.
// Assumes reset sources arrive as one-cycle strobes synchronous to pclk,
// and that the core samples pc_start when pc_load pulses.
//
// How it works
// RULE_01: Power control bits 6:3 read zero.
// RULE_02: Bit 7 mirrors parity-check config, read-only.
// RULE_03: Parity reset clears fault flag; power-on sets.
// RULE_04: Software writes fault flag; kept until parity.
// RULE_05: Power-on flag cleared only by power-on.
// RULE_06: Software sets power-on flag; zero means power-on.
// RULE_07: Brown-out reset clears brownout flag.
// RULE_08: Software arms brownout flag; don't-care if disabled.
// RULE_09: Expiry flag set by power, clear, sleep.
// RULE_10: Sleep flag set by power/clear; sleep clears.
// RULE_11: Wake continues at PC+1, vector if enabled.
// RULE_12: Wake-up leaves source flag set.
// RULE_13: Three initialisation classes for reset kinds.
// RULE_14: Unimplemented reset status bits read zero.
// RULE_15: Unchanged cause bits keep their set value.
// RULE_16: Indirect bank bit picks banks 2-3 or 0-1.
// RULE_17: Two-bit field picks one of four banks.
// RULE_18: Small variants keep indirect bank bit clear.
// RULE_19: Zero flag follows zero result.
// RULE_20: Nibble carry from bit 3, inverted for subtract.
// RULE_21: Carry from MSB; subtract adds two's complement.
// RULE_22: Rotates load carry from source edge bit.
// RULE_23: Non-wake resets start program at zero.
`timescale 1ns/1ps

module rcs_core #(
	parameter logic HAS_BROWNOUT = 1'b1,   // Variant has brown-out detection
	parameter logic HAS_PARITY   = 1'b1,   // Variant has parity-error reset
	parameter logic HAS_HI_BANKS = 1'b1    // Variant has banks 2 and 3
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire rcs_pkg::rcs_event_s   reset_event,
	input  wire logic                  parity_check_enable_mirror,
	input  wire logic                  brownout_config_enable,
	input  wire logic                  watchdog_clear_instr,
	input  wire logic                  sleep_instr,
	input  wire logic                  global_interrupt_enable,
	input  wire logic [12:0]           pc_current,
	input  wire rcs_pkg::rcs_alu_s     alu_in,
	output logic      [7:0]            alu_result,
	output logic      [12:0]           pc_start,
	output logic                       pc_load,
	output rcs_pkg::rcs_class_e        init_class,
	output logic                       interrupt_control_reg_flag,
	output logic                       peripheral_flag_reg1_flag,
	output logic      [8:0]            indirect_base,
	output logic      [8:0]            direct_base
);

	// ==========================================================
	// State registers
	rcs_pkg::rcs_state_s state_q;   // Registered state
	rcs_pkg::rcs_state_s state_d;   // Next state

	// ==========================================================
	// Bus decode
	logic        wr_en;     // Write accepted this cycle
	logic        rd_en;     // Read accepted this cycle
	logic        addr_ok;   // Address hits a mapped register
	logic [7:0]  pcr_view;  // Power control as software reads it
	logic [8:0]  sum9;      // Full-width ALU sum
	logic [4:0]  sum5;      // Low-nibble sum
	logic [7:0]  b_eff;     // Second operand after negation
	logic        cin;       // Carry in for subtract

	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign addr_ok = (paddr == rcs_pkg::OFS_POWER_RESET_CAUSE)
	               | (paddr == rcs_pkg::OFS_CORE_STATUS)
	               | (paddr == rcs_pkg::OFS_CAUSE_CTRL)
	               | (paddr == rcs_pkg::OFS_PC_START)
	               | (paddr == rcs_pkg::OFS_WAKE_SOURCE);
	// Unmapped addresses answer with an error, no side effects
	assign pslverr = psel & penable & ~addr_ok;

	// ==========================================================
	// Read view: mirror is live, middle bits zero, absent bits zero
	always_comb begin
		pcr_view = 8'h00;                                       // RULE_01
		pcr_view[rcs_pkg::PCR_PARITY_MIRROR] =
			parity_check_enable_mirror;                         // RULE_02
		pcr_view[rcs_pkg::PCR_PARITY_FAULT] =
			state_q.pcr[rcs_pkg::PCR_PARITY_FAULT] & HAS_PARITY; // RULE_14
		pcr_view[rcs_pkg::PCR_POWER_ON] =
			state_q.pcr[rcs_pkg::PCR_POWER_ON];
		// Brown-out flag is meaningless with detection off
		pcr_view[rcs_pkg::PCR_BROWNOUT] =
			state_q.pcr[rcs_pkg::PCR_BROWNOUT] & HAS_BROWNOUT; // RULE_14 RULE_08
	end

	// ==========================================================
	// ALU flag arithmetic: subtract adds the two's complement
	always_comb begin
		cin   = (alu_in.op == rcs_pkg::RCS_ALU_SUB);             // RULE_21
		b_eff = cin ? ~alu_in.b : alu_in.b;                      // RULE_21
		sum9  = {1'b0, alu_in.a} + {1'b0, b_eff} + {8'h00, cin};
		sum5  = {1'b0, alu_in.a[3:0]} + {1'b0, b_eff[3:0]}
		      + {4'h0, cin};
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_d          = state_q;
		state_d.pc_load  = 1'b0;
		state_d.rclass   = rcs_pkg::RCS_CLASS_NONE;
		alu_result       = 8'h00;

		// Software writes: flags are written to one after a reset
		if (wr_en && paddr == rcs_pkg::OFS_POWER_RESET_CAUSE && pstrb[0]) begin
			state_d.pcr[2:0] = pwdata[2:0];                  // RULE_04 RULE_06
		end
		if (wr_en && paddr == rcs_pkg::OFS_CORE_STATUS && pstrb[0]) begin
			// Expiry and sleep flags are read-only
			state_d.cst[7:5] = pwdata[7:5];                           // RULE_17
			state_d.cst[2:0] = pwdata[2:0];
			// Small variants force the upper-bank bit clear
			if (!HAS_HI_BANKS) begin
				state_d.cst[rcs_pkg::CST_INDIRECT_BANK] = 1'b0;       // RULE_18
			end
		end
		if (wr_en && paddr == rcs_pkg::OFS_WAKE_SOURCE && pstrb[0]) begin
			// Write one to clear a wake-source flag
			state_d.wake_src = state_q.wake_src & ~pwdata[1:0];
		end

		// ALU flag updates
		unique case (alu_in.op)
			rcs_pkg::RCS_ALU_ADD, rcs_pkg::RCS_ALU_SUB: begin
				alu_result = sum9[7:0];
				state_d.cst[rcs_pkg::CST_CARRY]        = sum9[8];  // RULE_21
				state_d.cst[rcs_pkg::CST_NIBBLE_CARRY] = sum5[4];  // RULE_20
				state_d.cst[rcs_pkg::CST_ZERO] = (sum9[7:0] == 8'h00); // RULE_19
			end
			rcs_pkg::RCS_ALU_LOGIC: begin
				alu_result = alu_in.a;
				state_d.cst[rcs_pkg::CST_ZERO] = (alu_in.a == 8'h00); // RULE_19
			end
			rcs_pkg::RCS_ALU_RLF: begin
				alu_result = {alu_in.a[6:0], state_q.cst[rcs_pkg::CST_CARRY]};
				state_d.cst[rcs_pkg::CST_CARRY] = alu_in.a[7];       // RULE_22
			end
			rcs_pkg::RCS_ALU_RRF: begin
				alu_result = {state_q.cst[rcs_pkg::CST_CARRY], alu_in.a[7:1]};
				state_d.cst[rcs_pkg::CST_CARRY] = alu_in.a[0];       // RULE_22
			end
			default: begin
				alu_result = 8'h00;
			end
		endcase

		// Instruction effects on the reset-cause status bits
		if (watchdog_clear_instr) begin
			state_d.cst[rcs_pkg::CST_WDOG_EXPIRY]   = 1'b1;        // RULE_09
			state_d.cst[rcs_pkg::CST_SLEEP_ENTERED] = 1'b1;        // RULE_10
		end else if (sleep_instr) begin
			state_d.cst[rcs_pkg::CST_WDOG_EXPIRY]   = 1'b1;        // RULE_09
			state_d.cst[rcs_pkg::CST_SLEEP_ENTERED] = 1'b0;        // RULE_10
		end

		// Reset and wake events, highest priority last so they win
		// over software writes in the same cycle
		if (reset_event.int_wake) begin
			state_d.rclass  = rcs_pkg::RCS_CLASS_WAKE;               // RULE_13
			state_d.cst[4:3] = 2'b10;
			state_d.wake_src[rcs_pkg::WAKE_INT_BIT] = 1'b1;          // RULE_12
			state_d.pc_start = global_interrupt_enable
				? rcs_pkg::PC_INT_VECTOR : pc_current + 13'h0001;   // RULE_11
			state_d.pc_load = 1'b1;
		end
		if (reset_event.wdog_wake) begin
			state_d.rclass   = rcs_pkg::RCS_CLASS_WAKE;              // RULE_13
			state_d.cst[4:3] = 2'b00;
			state_d.wake_src[rcs_pkg::WAKE_TIMER_BIT] = 1'b1;        // RULE_12
			state_d.pc_start = pc_current + 13'h0001;               // RULE_11
			state_d.pc_load  = 1'b1;
		end
		// Pin and watchdog warm resets leave power control untouched
		if (reset_event.pin_reset_run) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_WARM;                // RULE_13 RULE_15
			state_d.cst[7:5] = 3'b000;
		end
		if (reset_event.pin_reset_sleep) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_WARM;                // RULE_13
			state_d.cst[7:3] = 5'b00010;
		end
		if (reset_event.wdog_reset) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_WARM;                // RULE_13
			state_d.cst[7:3] = 5'b00001;                             // RULE_09
		end
		if (reset_event.parity && HAS_PARITY) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_WARM;
			state_d.pcr[rcs_pkg::PCR_PARITY_FAULT] = 1'b0;            // RULE_03
		end
		if (reset_event.brownout && HAS_BROWNOUT && brownout_config_enable) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_POWER;               // RULE_13
			state_d.cst[7:3] = 5'b00011;
			state_d.pcr[rcs_pkg::PCR_BROWNOUT] = 1'b0;               // RULE_07
		end
		if (reset_event.power_on) begin
			state_d.rclass = rcs_pkg::RCS_CLASS_POWER;               // RULE_13
			state_d.cst[7:3] = 5'b00011;                              // RULE_09 RULE_10
			state_d.pcr[rcs_pkg::PCR_POWER_ON]     = 1'b0;           // RULE_05
			state_d.pcr[rcs_pkg::PCR_PARITY_FAULT] = 1'b1;           // RULE_03
		end
		// Any non-wake reset restarts at address zero
		if (state_d.rclass == rcs_pkg::RCS_CLASS_POWER
		    || state_d.rclass == rcs_pkg::RCS_CLASS_WARM) begin
			state_d.pc_start = rcs_pkg::PC_RESET_VECTOR;             // RULE_23
			state_d.pc_load  = 1'b1;
		end

	end

	// Read data is combinational from the live view so the
	// zero-wait answer is correct in the access cycle itself
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				rcs_pkg::OFS_POWER_RESET_CAUSE: prdata = {24'h0, pcr_view};
				rcs_pkg::OFS_CORE_STATUS: prdata = {24'h0, state_q.cst};
				rcs_pkg::OFS_CAUSE_CTRL: prdata = {30'h0, state_q.rclass};
				rcs_pkg::OFS_PC_START: prdata = {19'h0, state_q.pc_start};
				rcs_pkg::OFS_WAKE_SOURCE: prdata = {30'h0, state_q.wake_src};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q          <= '0;
			state_q.pcr      <= rcs_pkg::PCR_RESET;
			state_q.cst      <= rcs_pkg::CST_RESET;
			state_q.pc_start <= rcs_pkg::PC_RESET_VECTOR;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Outputs and bank decode
	assign pc_start   = state_q.pc_start;
	assign pc_load    = state_q.pc_load;
	assign init_class = state_q.rclass;
	assign interrupt_control_reg_flag =
		state_q.wake_src[rcs_pkg::WAKE_INT_BIT];
	assign peripheral_flag_reg1_flag =
		state_q.wake_src[rcs_pkg::WAKE_TIMER_BIT];
	// Indirect: bit selects 100h-1FFh or 00h-FFh
	assign indirect_base = {state_q.cst[rcs_pkg::CST_INDIRECT_BANK], 8'h00}; // RULE_16
	// Direct: two bits choose a 128-byte bank
	assign direct_base = {state_q.cst[6:5], 7'h00};                 // RULE_17

endmodule : rcs_core

// [tb/rcs_assertions.sv]
// Checker for the reset-cause and core status block.
// Assumes it is bound to rcs_core and sees only its ports.
`timescale 1ns/1ps

module rcs_assertions (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire rcs_pkg::rcs_event_s reset_event,
	input wire logic                parity_check_enable_mirror,
	input wire logic [12:0]         pc_current,
	input wire rcs_pkg::rcs_alu_s   alu_in,
	input wire logic [7:0]          alu_result,
	input wire logic [12:0]         pc_start,
	input wire logic                pc_load,
	input wire rcs_pkg::rcs_class_e init_class,
	input wire logic                interrupt_control_reg_flag,
	input wire logic                peripheral_flag_reg1_flag
);
	// ==========================================================
	// Helper terms
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Read access cycle of the power register
	wire pcr_rd = psel && penable && !pwrite && paddr == 12'h000;
	// Any reset that outranks a wake-up
	wire hi_rst = reset_event.power_on || reset_event.brownout ||
		reset_event.parity || reset_event.pin_reset_run ||
		reset_event.pin_reset_sleep || reset_event.wdog_reset;
	// Pin and watchdog resets, no power-on, brown-out or parity reset beside them
	wire warm = (reset_event.pin_reset_run ||
		reset_event.pin_reset_sleep ||
		reset_event.wdog_reset) && !reset_event.power_on &&
		!reset_event.brownout && !reset_event.parity;
	wire wake = reset_event.wdog_wake || reset_event.int_wake;

	// ==========================================================
	// Assertions
	mirror_bit_a: assert property (pcr_rd |->
		prdata[7] == parity_check_enable_mirror) else $error("mirror bit");
	pcr_gap_a: assert property (pcr_rd |-> prdata[6:3] == 4'h0)
		else $error("power reg gap bits not zero");
	rst_vector_a: assert property (hi_rst && !reset_event.brownout |=>
		pc_load && pc_start == 13'h0000) else $error("reset vector");
	wake_pc_a: assert property (reset_event.wdog_wake && !hi_rst |=>
		pc_load && pc_start == $past(pc_current) + 13'h0001)
		else $error("wake start address");
	class_power_a: assert property (reset_event.power_on |=>
		init_class == rcs_pkg::RCS_CLASS_POWER) else $error("power class");
	class_warm_a: assert property (warm |=>
		init_class == rcs_pkg::RCS_CLASS_WARM) else $error("warm class");
	class_wake_a: assert property (wake && !hi_rst |=>
		init_class == rcs_pkg::RCS_CLASS_WAKE && (interrupt_control_reg_flag
		|| peripheral_flag_reg1_flag)) else $error("wake class or flag");
	add_sum_a: assert property (alu_in.op == rcs_pkg::RCS_ALU_ADD |->
		alu_result == 8'(alu_in.a + alu_in.b)) else $error("add result");
	sub_diff_a: assert property (alu_in.op == rcs_pkg::RCS_ALU_SUB |->
		alu_result == 8'(alu_in.a + ~alu_in.b + 8'h01))
		else $error("subtract result");
	bus_answer_a: assert property (psel && penable |-> pready and
		(paddr == 12'h014 |-> pslverr)) else $error("bus answer");

	// Main scenarios reached
	power_c: cover property (reset_event.power_on);
	wdog_wake_c: cover property (reset_event.wdog_wake);
	int_wake_c: cover property (reset_event.int_wake);
	unmapped_c: cover property (psel && penable && pslverr);
endmodule // rcs_assertions

bind rcs_core rcs_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.reset_event(reset_event),
	.parity_check_enable_mirror(parity_check_enable_mirror),
	.pc_current(pc_current), .alu_in(alu_in), .alu_result(alu_result),
	.pc_start(pc_start), .pc_load(pc_load), .init_class(init_class),
	.interrupt_control_reg_flag(interrupt_control_reg_flag),
	.peripheral_flag_reg1_flag(peripheral_flag_reg1_flag));

// [tb/testbench.sv]
// Self-checking bench for the reset-cause and core status block.
// Assumes a zero-wait APB slave and one-cycle reset-source strobes.
`timescale 1ns/1ps

module testbench;
	// ==========================================================
	// Signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pc_load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic mir, boe, wclr, slp, int_en, icf, pff, e2;
	logic [12:0] pcc, pc_start;
	logic [7:0]  alu_result;
	logic [8:0]  ib, db;
	rcs_pkg::rcs_event_s reset_event;
	rcs_pkg::rcs_alu_s   alu_in;
	rcs_pkg::rcs_class_e init_class;
	int n_mismatch, comparisons, cyc;

	rcs_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_event(reset_event), .parity_check_enable_mirror(mir),
		.brownout_config_enable(boe), .watchdog_clear_instr(wclr),
		.sleep_instr(slp), .global_interrupt_enable(int_en),
		.pc_current(pcc),
		.alu_in(alu_in), .alu_result(alu_result), .pc_start(pc_start),
		.pc_load(pc_load), .init_class(init_class),
		.interrupt_control_reg_flag(icf), .peripheral_flag_reg1_flag(pff),
		.indirect_base(ib), .direct_base(db));

	// ==========================================================
	// Clock and a hang guard sized well above the whole run
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// Only the bench-wide cycle guard ends a wait that never answers
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, r, e2);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(0, a, 0, r, e2);
		chk(nm, r, e);
	endtask
	// Fire one reset source from a known register state, then judge it
	task automatic fire(input logic [7:0] ev, input logic [7:0] pexp,
		input logic [4:0] sexp, input logic [12:0] pce, input logic [1:0] ce,
		input logic full);
		// Arm the flags; before power-on the fault flag is left clear
		// so that its forced set is visible
		wr(12'h000, (ev == 8'h80) ? 32'h03 : 32'h07);
		wr(12'h004, 32'he7);
		@(posedge pclk);
		reset_event <= rcs_pkg::rcs_event_s'(ev);
		@(posedge pclk);
		reset_event <= '0;
		#1 chk("pc_load", pc_load, 1);
		chk("pc_start", pc_start, pce);
		if (full) chk("init_class", init_class, ce);
		@(posedge pclk);
		#1 chk("pc_load_end", pc_load, 0);
		rd_chk("power_reg", 12'h000, pexp);
		apb(0, 12'h004, 0, r, e2);
		if (full) chk("status", r[7:3], sexp);
	endtask
	// Pulse a core instruction strobe, then read the two status flags
	task automatic instr(input logic clr, input logic [1:0] e);
		@(posedge pclk);
		wclr <= clr; slp <= !clr;
		@(posedge pclk);
		wclr <= 0; slp <= 0;
		apb(0, 12'h004, 0, r, e2);
		chk("status_to_pd", r[4:3], e);
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_registers();
		rd_chk("power_reset", 12'h000, 32'h80);
		rd_chk("status_reset", 12'h004, 32'h18);
		wr(12'h000, 32'hff);
		rd_chk("power_wr", 12'h000, 32'h87);
		mir <= 0;
		rd_chk("power_mirror", 12'h000, 32'h07);
		apb(0, 12'h014, 0, r, e2);
		chk("unmapped_err", e2, 1);
	endtask
	task automatic t_events();
		fire(8'h80, 8'h05, 5'b00011, 13'h0, 2'b01, 1);
		fire(8'h40, 8'h06, 5'b00011, 13'h0, 2'b01, 1);
		fire(8'h10, 8'h07, 5'b00011, 13'h0, 2'b11, 1);
		fire(8'h04, 8'h07, 5'b00001, 13'h0, 2'b11, 1);
		fire(8'h08, 8'h07, 5'b00010, 13'h0, 2'b11, 1);
		fire(8'h02, 8'h07, 5'b11100, 13'h0124, 2'b10, 1);
		chk("wake_flag", icf | pff, 1);
		rd_chk("wake_src_wdog", 12'h010, 32'h01);
		fire(8'h01, 8'h07, 5'b11110, 13'h0124, 2'b10, 1);
		rd_chk("wake_src_int", 12'h010, 32'h03);
		wr(12'h010, 32'h03);
		rd_chk("wake_src_clr", 12'h010, 32'h00);
		// Interrupt wake with interrupts enabled goes to the vector
		int_en <= 1;
		fire(8'h01, 8'h07, 5'b11110, 13'h0004, 2'b10, 1);
		int_en <= 0;
		fire(8'h20, 8'h03, 5'b0, 13'h0, 2'b0, 0);
		rd_chk("parity_kept", 12'h000, 32'h03);
		instr(1, 2'b11);
		instr(0, 2'b10);
		// Detection off: a brown-out strobe must not restart the core
		boe <= 0;
		@(posedge pclk);
		reset_event <= rcs_pkg::rcs_event_s'(8'h40);
		@(posedge pclk);
		reset_event <= '0;
		#1 chk("bo_off_load", pc_load, 0);
	endtask
	task automatic t_alu();
		logic [2:0] op[7] = '{1, 1, 2, 2, 3, 4, 5};
		logic [7:0] a[7] = '{8'h0f, 8'hff, 8'h10, 8'h00, 8'h00, 8'h80, 8'h80};
		logic [7:0] b[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
		logic [7:0] res[7] = '{8'h10, 8'h00, 8'h0f, 8'hff, 8'h00, 0, 0};
		logic [2:0] fl[7] = '{3'b010, 3'b111, 3'b001, 3'b000, 3'b100, 1, 0};
		logic [2:0] mk[7] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h1, 3'h1};
		for (int i = 0; i < 7; i++) begin
			@(posedge pclk);
			alu_in <= '{rcs_pkg::rcs_alu_e'(op[i]), a[i], b[i]};
			#1 if (i < 5) chk("alu_result", alu_result, res[i]);
			@(posedge pclk);
			alu_in <= '0;
			apb(0, 12'h004, 0, r, e2);
			chk("alu_flags", r[2:0] & mk[i], fl[i]);
		end
	endtask
	task automatic t_banks();
		for (int k = 0; k < 8; k++) begin
			wr(12'h004, 32'(k) << 5);
			repeat (2) @(posedge pclk);
			#1 chk("direct_base", db, 9'(k % 4) << 7);
			chk("indirect_base", ib, (k > 3) ? 9'h100 : 9'h000);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		n_mismatch = 0; comparisons = 0; cyc = 0;
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; pstrb = 4'hf; reset_event = '0; mir = 1; boe = 1;
		wclr = 0; slp = 0; int_en = 0; pcc = 13'h0123; alu_in = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_registers();
		t_events();
		t_alu();
		t_banks();
		report_and_stop();
	end
endmodule // testbench
